// >>> pkg/bsc_pkg.sv
// shared constants and types for the boundary scan chain
package bsc_pkg;

	// chain geometry
	localparam int CHAIN_LEN = 213;
	// cell fed by the serial input (trigger output pin, input cell)
	localparam int CELL_FIRST = 0;
	// cell that feeds the serial output (port d bit 0, enable cell)
	localparam int CELL_LAST = 212;

	// landmark cells along the chain, lowest number nearest the serial input
	localparam int CELL_TRIG_IN = 0;
	localparam int CELL_TRIG_OUT = 1;
	localparam int CELL_TRIG_OE = 2;
	localparam int CELL_HALT_SLEEP = 3;
	localparam int CELL_INSTR_FETCH = 10;
	localparam int CELL_STROBE_OE = 12;
	localparam int CELL_DATA_FIRST = 18;
	localparam int CELL_DATA_LAST = 33;
	localparam int CELL_DATA_OE = 34;
	localparam int CELL_CHIP_SEL_FIRST = 35;
	localparam int CELL_ADDR_FIRST = 39;
	localparam int CELL_ADDR_HI_OE = 55;
	localparam int CELL_PORT_A_BIT7 = 111;
	localparam int CELL_SERIAL_FIRST = 137;

	// instruction register
	localparam int IR_LEN = 4;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] INS_EXTEST = 4'h0;
	localparam logic [3:0] INS_SAMPLE = 4'h1;
	localparam logic [3:0] INS_PRELOAD = 4'h2;
	localparam logic [3:0] INS_IDCODE = 4'h3;
	localparam logic [3:0] INS_BYPASS = 4'hf;
	// instruction selected after any test port reset
	localparam logic [3:0] INS_RESET = INS_IDCODE;

	// identification word, value is arbitrary
	localparam logic [31:0] ID_WORD = 32'h0000_0001;

	// timing: system clock and the test clock strap
	localparam int SYS_PERIOD_NS = 10;
	localparam int STRAP_LOW_NS = 20;
	localparam int STRAP_LOW_CYCLES = (STRAP_LOW_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	// least time each test clock level is held, in system cycles
	localparam int TCK_MIN_CYCLES = 2;

	// reset values
	localparam logic RST_TCK = 1'b1;
	localparam logic RST_TDO = 1'b0;

	// test port pins as seen by the device
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
		logic trst_n;
	} bsc_jtag_in_s;

	// serial output pin with its enable
	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} bsc_jtag_out_s;

	// test port controller states
	typedef enum logic [3:0] {
		TAP_RESET,
		TAP_IDLE,
		TAP_SEL_DR,
		TAP_CAP_DR,
		TAP_SHIFT_DR,
		TAP_EXIT1_DR,
		TAP_PAUSE_DR,
		TAP_EXIT2_DR,
		TAP_UPD_DR,
		TAP_SEL_IR,
		TAP_CAP_IR,
		TAP_SHIFT_IR,
		TAP_EXIT1_IR,
		TAP_PAUSE_IR,
		TAP_EXIT2_IR,
		TAP_UPD_IR
	} bsc_tap_e;

endpackage : bsc_pkg

// >>> core/bsc_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; the output moves only when stages two and three agree
module bsc_sync3 #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// no reset on purpose: the stages must show the pin level before reset release
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] level;
	} bsc_sync_s;

	bsc_sync_s st;
	bsc_sync_s next_st;

	// stage one feeds stage two only
	always_comb begin
		next_st = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			// accept a change once two stages agree
			if (st.s2[i] == st.s3[i]) begin
				next_st.level[i] = st.s3[i];
			end
		end
	end

	// register the whole state
	always_ff @(posedge clock) begin
		st <= next_st;
	end

	assign q = st.level;

endmodule : bsc_sync3

// >>> core/bsc_chain.sv
`timescale 1ns/1ps
// Behaviour
// - all signal pins except test, supply, crystal
// - each cell has shift and update stage
// - cells observe and control their signal
// - enable cells for bidirectional, open-drain pins
// - serial input to cell 0, cell 212 out
// - cells ordered clockwise by pin position
// - per pin: input, output, then enable
// - chain holds exactly 213 cells
// - address byte groups share one enable cell
// - cell 34 steers all data pins
// - cell 12 enables the five strobes
// - cells 0-10 trigger and control signals
// - data pairs 18-33, chip selects 35-38
// - address from 39, ports from 111, serial 137
// - capture, shift on rise; update on fall
// - decode bypass, sample, extest, preload, idcode
// - serial output changes on falling test clock
module bsc_chain (
	input wire logic clock,
	input wire logic nrst,
	// test port pins, asynchronous to clock
	input wire bsc_pkg::bsc_jtag_in_s jtag_in,
	// serial output pin and its enable
	output bsc_pkg::bsc_jtag_out_s jtag_out,
	// bit n of the three cell vectors is cell n; the top level wires pins in this order
	// every scanned signal owns bits
	// address 39, ports 111, serial 137
	// observed value of every cell: pin level, or core output and enable
	input wire logic [bsc_pkg::CHAIN_LEN-1:0] cell_observe,
	// functional value that each cell passes through in normal mode
	input wire logic [bsc_pkg::CHAIN_LEN-1:0] cell_func,
	// value that reaches each pin, output or enable
	output logic [bsc_pkg::CHAIN_LEN-1:0] cell_drive,
	// high while the test port was enabled at reset release
	output logic test_active
);

	// whole block state
	typedef struct packed {
		bsc_pkg::bsc_tap_e tap;
		logic [bsc_pkg::IR_LEN-1:0] ir_shift;
		logic [bsc_pkg::IR_LEN-1:0] instr;
		logic [bsc_pkg::CHAIN_LEN-1:0] bsr;
		logic [bsc_pkg::CHAIN_LEN-1:0] upd;
		logic [bsc_pkg::CHAIN_LEN-1:0] drive;
		logic [31:0] id_shift;
		logic byp;
		logic tdo;
		logic tdo_oe;
		logic tck_prev;
		logic active;
		logic strap_done;
		// cycles waited after release before the strap is read
		logic [1:0] strap_wait;
	} bsc_state_s;

	bsc_state_s st;
	bsc_state_s next_st;

	// synchronised test port pins
	bsc_pkg::bsc_jtag_in_s jin;
	// synchronised cell observations
	logic [bsc_pkg::CHAIN_LEN-1:0] obs;
	// test clock edges seen in the system clock domain
	logic tck_rise;
	logic tck_fall;
	// serial output of the selected data register
	logic dr_out;
	// true while the instruction lets the update stage reach pins
	logic pin_test;

	// standard controller transitions, taken on a rising test clock
	function automatic bsc_pkg::bsc_tap_e bsc_tap_next(input bsc_pkg::bsc_tap_e s, input logic tms);
		case (s)
			bsc_pkg::TAP_RESET: bsc_tap_next = tms ? bsc_pkg::TAP_RESET : bsc_pkg::TAP_IDLE;
			bsc_pkg::TAP_IDLE: bsc_tap_next = tms ? bsc_pkg::TAP_SEL_DR : bsc_pkg::TAP_IDLE;
			bsc_pkg::TAP_SEL_DR: bsc_tap_next = tms ? bsc_pkg::TAP_SEL_IR : bsc_pkg::TAP_CAP_DR;
			bsc_pkg::TAP_CAP_DR: bsc_tap_next = tms ? bsc_pkg::TAP_EXIT1_DR : bsc_pkg::TAP_SHIFT_DR;
			bsc_pkg::TAP_SHIFT_DR: bsc_tap_next = tms ? bsc_pkg::TAP_EXIT1_DR : bsc_pkg::TAP_SHIFT_DR;
			bsc_pkg::TAP_EXIT1_DR: bsc_tap_next = tms ? bsc_pkg::TAP_UPD_DR : bsc_pkg::TAP_PAUSE_DR;
			bsc_pkg::TAP_PAUSE_DR: bsc_tap_next = tms ? bsc_pkg::TAP_EXIT2_DR : bsc_pkg::TAP_PAUSE_DR;
			bsc_pkg::TAP_EXIT2_DR: bsc_tap_next = tms ? bsc_pkg::TAP_UPD_DR : bsc_pkg::TAP_SHIFT_DR;
			bsc_pkg::TAP_UPD_DR: bsc_tap_next = tms ? bsc_pkg::TAP_SEL_DR : bsc_pkg::TAP_IDLE;
			bsc_pkg::TAP_SEL_IR: bsc_tap_next = tms ? bsc_pkg::TAP_RESET : bsc_pkg::TAP_CAP_IR;
			bsc_pkg::TAP_CAP_IR: bsc_tap_next = tms ? bsc_pkg::TAP_EXIT1_IR : bsc_pkg::TAP_SHIFT_IR;
			bsc_pkg::TAP_SHIFT_IR: bsc_tap_next = tms ? bsc_pkg::TAP_EXIT1_IR : bsc_pkg::TAP_SHIFT_IR;
			bsc_pkg::TAP_EXIT1_IR: bsc_tap_next = tms ? bsc_pkg::TAP_UPD_IR : bsc_pkg::TAP_PAUSE_IR;
			bsc_pkg::TAP_PAUSE_IR: bsc_tap_next = tms ? bsc_pkg::TAP_EXIT2_IR : bsc_pkg::TAP_PAUSE_IR;
			bsc_pkg::TAP_EXIT2_IR: bsc_tap_next = tms ? bsc_pkg::TAP_UPD_IR : bsc_pkg::TAP_SHIFT_IR;
			bsc_pkg::TAP_UPD_IR: bsc_tap_next = tms ? bsc_pkg::TAP_SEL_DR : bsc_pkg::TAP_IDLE;
			default: bsc_tap_next = bsc_pkg::TAP_RESET;
		endcase
	endfunction : bsc_tap_next

	// true for the instructions that route the scan register between pins and serial port
	function automatic logic bsc_uses_bsr(input logic [bsc_pkg::IR_LEN-1:0] ins);
		bsc_uses_bsr = (ins == bsc_pkg::INS_EXTEST) || (ins == bsc_pkg::INS_SAMPLE) ||
			(ins == bsc_pkg::INS_PRELOAD);
	endfunction : bsc_uses_bsr

	// test port pins cross into the system clock here
	bsc_sync3 #(
		.W($bits(bsc_pkg::bsc_jtag_in_s))
	) u_sync_jtag (
		.clock(clock),
		.d(jtag_in),
		.q(jin)
	);

	// pin observations cross as well; they are only sampled at capture instants
	bsc_sync3 #(
		.W(bsc_pkg::CHAIN_LEN)
	) u_sync_obs (
		.clock(clock),
		.d(cell_observe),
		.q(obs)
	);

	// edge finding relies on a test clock period of at least four system cycles, each level held for two
	// period limit assumed
	assign tck_rise = jin.tck & ~st.tck_prev;
	assign tck_fall = ~jin.tck & st.tck_prev;

	// data register selected by the current instruction
	always_comb begin
		if (bsc_uses_bsr(st.instr)) begin
			dr_out = st.bsr[bsc_pkg::CELL_LAST];
		end else if (st.instr == bsc_pkg::INS_IDCODE) begin
			dr_out = st.id_shift[0];
		end else begin
			// unknown codes behave as bypass
			dr_out = st.byp;
		end
	end

	assign pin_test = st.active && (st.instr == bsc_pkg::INS_EXTEST);

	// next state of the whole block
	always_comb begin
		next_st = st;
		next_st.tck_prev = jin.tck;
		// pins follow the update stage only under a pin-driving instruction
		next_st.drive = pin_test ? st.upd : cell_func;
		if (!st.strap_done) begin
			if (st.strap_wait == 2'(bsc_pkg::STRAP_LOW_CYCLES)) begin
				// by now the synchroniser shows the pin as it stood at release
				next_st.strap_done = 1'b1;
				next_st.active = ~jin.tck;
			end else begin
				// too early: the synchroniser may still carry an older level
				next_st.strap_wait = 2'(st.strap_wait + 2'h1);
			end
		end
		if (!st.active || !jin.trst_n || st.tap == bsc_pkg::TAP_RESET) begin
			if (!st.active || !jin.trst_n) begin
				next_st.tap = bsc_pkg::TAP_RESET;
				next_st.tdo_oe = 1'b0;
			end
			next_st.instr = bsc_pkg::INS_RESET;
			next_st.upd = '0;
		end
		if (st.active && jin.trst_n) begin
			if (tck_rise) begin
				case (st.tap)
					bsc_pkg::TAP_CAP_DR: begin
						if (st.instr == bsc_pkg::INS_EXTEST || st.instr == bsc_pkg::INS_SAMPLE) begin
							next_st.bsr = obs;
						end else if (st.instr == bsc_pkg::INS_IDCODE) begin
							next_st.id_shift = bsc_pkg::ID_WORD;
						end else if (!bsc_uses_bsr(st.instr)) begin
							next_st.byp = 1'b0;
						end
					end
					bsc_pkg::TAP_SHIFT_DR: begin
						if (bsc_uses_bsr(st.instr)) begin
							next_st.bsr = {st.bsr[bsc_pkg::CHAIN_LEN-2:0], jin.tdi};
						end else if (st.instr == bsc_pkg::INS_IDCODE) begin
							next_st.id_shift = {jin.tdi, st.id_shift[31:1]};
						end else begin
							next_st.byp = jin.tdi;
						end
					end
					bsc_pkg::TAP_CAP_IR: begin
						next_st.ir_shift = bsc_pkg::IR_CAPTURE;
					end
					bsc_pkg::TAP_SHIFT_IR: begin
						next_st.ir_shift = {jin.tdi, st.ir_shift[bsc_pkg::IR_LEN-1:1]};
					end
					default: begin
						// other states hold their registers
					end
				endcase
				next_st.tap = bsc_tap_next(st.tap, jin.tms);
			end
			if (tck_fall) begin
				case (st.tap)
					bsc_pkg::TAP_SHIFT_DR: begin
						next_st.tdo = dr_out;
						next_st.tdo_oe = 1'b1;
					end
					bsc_pkg::TAP_SHIFT_IR: begin
						next_st.tdo = st.ir_shift[0];
						next_st.tdo_oe = 1'b1;
					end
					bsc_pkg::TAP_UPD_DR: begin
						if (bsc_uses_bsr(st.instr)) begin
							next_st.upd = st.bsr;
						end
						next_st.tdo_oe = 1'b0;
					end
					bsc_pkg::TAP_UPD_IR: begin
						next_st.instr = st.ir_shift;
						next_st.tdo_oe = 1'b0;
					end
					default: begin
						next_st.tdo_oe = 1'b0;
					end
				endcase
			end
		end
	end

	// single state register; the strap is read after release, never under reset
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			st <= '{tap: bsc_pkg::TAP_RESET, ir_shift: bsc_pkg::IR_CAPTURE, instr: bsc_pkg::INS_RESET,
				bsr: '0, upd: '0, drive: '0, id_shift: '0, byp: 1'b0, tdo: bsc_pkg::RST_TDO,
				tdo_oe: 1'b0, tck_prev: bsc_pkg::RST_TCK, active: 1'b0, strap_done: 1'b0, strap_wait: 2'h0};
		end else begin
			st <= next_st;
		end
	end

	// outputs come straight from the state register
	assign jtag_out = '{tdo: st.tdo, tdo_oe: st.tdo_oe};
	assign cell_drive = st.drive;
	assign test_active = st.active;

endmodule : bsc_chain

// >>> test/bsc_chain_monitor.sv
`timescale 1ns/1ps
// checker beside the chain; it sees the ports only
module bsc_chain_monitor (
	input wire logic clock,
	input wire logic nrst,
	input wire bsc_pkg::bsc_jtag_in_s jtag_in,
	input wire bsc_pkg::bsc_jtag_out_s jtag_out,
	input wire logic [bsc_pkg::CHAIN_LEN-1:0] cell_observe,
	input wire logic [bsc_pkg::CHAIN_LEN-1:0] cell_func,
	input wire logic [bsc_pkg::CHAIN_LEN-1:0] cell_drive,
	input wire logic test_active
);
	// one domain: the system clock
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_reset_clears_out: assert property (disable iff (1'b0) !nrst && !$past(nrst) |-> cell_drive == '0 && !jtag_out.tdo_oe)
		else $error("outputs not cleared in reset");
	a_mode_holds_steady: assert property ($past(nrst, 4) |-> $stable(test_active))
		else $error("test mode changed after release");
	// core in charge while the port is off
	a_idle_passes_func: assert property (!test_active |=> cell_drive == $past(cell_func))
		else $error("functional path lost");
	// disabled port never drives its output
	a_off_no_output: assert property (!test_active |-> !jtag_out.tdo_oe)
		else $error("serial output driven while disabled");
	// port reset restores the core path
	a_port_reset_func: assert property ((!jtag_in.trst_n) [*6] |=> cell_drive == $past(cell_func))
		else $error("port reset left pins under test");
	// port reset stops the serial output
	a_port_reset_quiet: assert property ((!jtag_in.trst_n) [*6] |-> !jtag_out.tdo_oe)
		else $error("serial output on during port reset");
	// serial output moves only after a falling test clock
	a_tdo_after_fall: assert property ($changed(jtag_out.tdo) |-> !$past(jtag_in.tck, 3))
		else $error("serial output moved outside low phase");
	// update stage reaches the pins only after a fall
	a_update_on_fall: assert property ($changed(cell_drive) && cell_drive != $past(cell_func)
		|-> !$past(jtag_in.tck, 3))
		else $error("update outside falling edge");
endmodule : bsc_chain_monitor

// >>> test/bsc_tester.sv
`timescale 1ns/1ps
// far-side tester: drives the test port at 80 ns per test clock
module bsc_tester (
	input wire logic clock,
	output bsc_pkg::bsc_jtag_in_s jtag_in,
	input wire bsc_pkg::bsc_jtag_out_s jtag_out
);
	// clock parked low before reset release
	initial jtag_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b1};
	// low half then high half; output taken late in the high half
	task automatic tick(input logic m, input logic d, output logic o);
		@(posedge clock);
		jtag_in.tck <= 1'b0;
		jtag_in.tms <= m;
		jtag_in.tdi <= d;
		repeat (4) @(posedge clock);
		jtag_in.tck <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		o = jtag_out.tdo;
	endtask : tick
	// from idle or reset: one ir or dr scan, then back to idle with the clock stopped
	task automatic scan(input logic ir, input int n, input logic [bsc_pkg::CHAIN_LEN-1:0] din,
		output logic [bsc_pkg::CHAIN_LEN-1:0] dout);
		logic o;
		dout = '0;
		// leaves the reset state, stays in idle otherwise
		tick(1'b0, 1'b0, o);
		tick(1'b1, 1'b0, o);
		if (ir) begin
			tick(1'b1, 1'b0, o);
		end
		tick(1'b0, 1'b0, o);
		tick(1'b0, 1'b0, o);
		// the whole register per scan; ir lsb first, dr top cell first
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, ir ? din[i] : din[n-1-i], o);
			dout[ir ? i : n-1-i] = o;
		end
		tick(1'b1, 1'b0, o);
		tick(1'b0, 1'b0, o);
		// released data line shows the inverse of its last level
		@(posedge clock);
		jtag_in.tck <= 1'b0;
		jtag_in.tdi <= ~jtag_in.tdi;
	endtask : scan
	// test port reset, held well past its synchroniser
	task automatic port_reset();
		@(posedge clock);
		jtag_in.trst_n <= 1'b0;
		repeat (10) @(posedge clock);
		jtag_in.trst_n <= 1'b1;
	endtask : port_reset
	// clock level for the next reset release
	task automatic set_tck(input logic v);
		@(posedge clock);
		jtag_in.tck <= v;
	endtask : set_tck
endmodule : bsc_tester

// >>> test/test_boundary_scan_chain.sv
`timescale 1ns/1ps
// bench: random pin values, scans through the tester model
module test_boundary_scan_chain;
	localparam int N = bsc_pkg::CHAIN_LEN;
	localparam logic [3:0] CODES [5] = '{bsc_pkg::INS_SAMPLE, bsc_pkg::INS_PRELOAD, bsc_pkg::INS_EXTEST,
		bsc_pkg::INS_BYPASS, bsc_pkg::INS_IDCODE};
	logic clock = 1'b0;
	logic nrst = 1'b0;
	bsc_pkg::bsc_jtag_in_s jtag_in;
	bsc_pkg::bsc_jtag_out_s jtag_out;
	logic [N-1:0] cell_observe = '0;
	logic [N-1:0] cell_func = '0;
	logic [N-1:0] obs_next = '0;
	logic [N-1:0] cell_drive;
	logic [N-1:0] func_prev;
	logic [N-1:0] din;
	logic [N-1:0] dout;
	logic [N-1:0] upd;
	logic test_active;
	logic [31:0] seed = 32'h26;
	int mismatches = 0;
	int samples_checked = 0;
	always #5 clock = ~clock;
	bsc_chain i_bsc_chain (.clock(clock), .nrst(nrst), .jtag_in(jtag_in), .jtag_out(jtag_out),
		.cell_observe(cell_observe), .cell_func(cell_func), .cell_drive(cell_drive), .test_active(test_active));
	bsc_tester i_bsc_tester (.clock(clock), .jtag_in(jtag_in), .jtag_out(jtag_out));
	// xorshift; drawn at rising edges by the driver, at falling edges by the sequence
	function automatic logic [N-1:0] rnd();
		logic [N-1:0] v;
		for (int i = 0; i < 7; i++) begin
			seed ^= seed << 13;
			seed ^= seed >> 17;
			seed ^= seed << 5;
			v = {v[N-33:0], seed};
		end
		return v;
	endfunction : rnd
	// core values change every cycle so a stale path shows
	always @(posedge clock) begin
		cell_func <= rnd();
		func_prev <= cell_func;
		cell_observe <= obs_next;
	end
	// pins follow the update stage only under extest
	function automatic logic [N-1:0] exp_drive(input logic [3:0] ins);
		return (ins == bsc_pkg::INS_EXTEST) ? upd : func_prev;
	endfunction : exp_drive
	// preload keeps the last load, bypass is one zero cell, idcode sends its word first
	function automatic logic [N-1:0] exp_out(input logic [3:0] ins);
		logic [N-1:0] e;
		e = '0;
		if (ins == bsc_pkg::INS_PRELOAD) begin
			return upd;
		end
		if (ins == bsc_pkg::INS_IDCODE) begin
			// id word lsb first, then the serial input delayed by its 32 bits
			for (int i = 0; i < 32; i++) begin
				e[N-1-i] = bsc_pkg::ID_WORD[i];
			end
			e[N-33:0] = din[N-1:32];
			return e;
		end
		return (ins == bsc_pkg::INS_BYPASS) ? {1'b0, din[N-1:1]} : obs_next;
	endfunction : exp_out
	task automatic check(input string what, input logic [N-1:0] exp, input logic [N-1:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop
	// bound on the whole run
	initial begin
		#400000;
		mismatches++;
		report_and_stop();
	end
	initial begin
		upd = '0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(negedge clock);
		check("test_active", N'(1), N'(test_active));
		check("drive idle", func_prev, cell_drive);
		$display("test reset done");
		// each instruction: ir load, then a full dr scan
		for (int k = 0; k < 5; k++) begin
			@(negedge clock);
			obs_next = rnd();
			din = rnd();
			i_bsc_tester.scan(1'b1, bsc_pkg::IR_LEN, N'(CODES[k]), dout);
			check("ir capture", N'(bsc_pkg::IR_CAPTURE), N'(dout[3:0]));
			@(negedge clock);
			check("drive after ir", exp_drive(CODES[k]), cell_drive);
			i_bsc_tester.scan(1'b0, N, din, dout);
			check("unloaded", exp_out(CODES[k]), dout);
			if (CODES[k] != bsc_pkg::INS_BYPASS && CODES[k] != bsc_pkg::INS_IDCODE) begin
				upd = din;
			end
			@(negedge clock);
			check("drive after dr", exp_drive(CODES[k]), cell_drive);
			$display("test instruction %h done", CODES[k]);
		end
		// port reset in mid extest
		i_bsc_tester.scan(1'b1, bsc_pkg::IR_LEN, N'(bsc_pkg::INS_EXTEST), dout);
		@(negedge clock);
		check("drive extest", upd, cell_drive);
		i_bsc_tester.port_reset();
		repeat (6) @(negedge clock);
		check("drive port reset", func_prev, cell_drive);
		$display("test port reset done");
		// release with the clock high leaves the port off
		i_bsc_tester.set_tck(1'b1);
		nrst <= 1'b0;
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(negedge clock);
		check("test_active off", '0, N'(test_active));
		i_bsc_tester.scan(1'b1, bsc_pkg::IR_LEN, N'(bsc_pkg::INS_EXTEST), dout);
		@(negedge clock);
		check("drive port off", func_prev, cell_drive);
		$display("test disabled port done");
		report_and_stop();
	end
endmodule : test_boundary_scan_chain
bind bsc_chain bsc_chain_monitor i_bsc_chain_monitor (.clock(clock), .nrst(nrst), .jtag_in(jtag_in),
	.jtag_out(jtag_out), .cell_observe(cell_observe), .cell_func(cell_func), .cell_drive(cell_drive),
	.test_active(test_active));
